// *** hw/hub_cfg_consts.svh ***
// Function
// - string lengths never exceed 31 characters
// - each string region holds 62 bytes
// - characters are 16-bit little-endian UTF-16
// - low byte at lower address, high next
// - characters sequential and gap-free
// - manufacturer bytes at 16h through 53h
// - product bytes at 54h through 91h
// - serial bytes at 92h through CFh
// - wait programmed milliseconds after select change
// - switch only ports whose select changed
// - delay debounces mechanical select switches
// - delay register resets to zero
`ifndef HUB_CFG_CONSTS_SVH
`define HUB_CFG_CONSTS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define ADDR_MFR_LEN 8'h13
`define ADDR_PRD_LEN 8'h14
`define ADDR_SER_LEN 8'h15
`define ADDR_MFR_FIRST 8'h16
`define ADDR_MFR_LAST 8'h53
`define ADDR_PRD_FIRST 8'h54
`define ADDR_PRD_LAST 8'h91
`define ADDR_SER_FIRST 8'h92
`define ADDR_SER_LAST 8'hcf
`define ADDR_DELAY 8'hd0
`define TEXT_BYTES 62
`define TEXT_MAX_CHARS 8'h1f
`define RESET_BYTE 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ 40000000
`define TICK_MS 1
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`endif

// *** hw/hub_cfg_pkg.sv ***
package hub_cfg_pkg;
   typedef enum logic [2:0] {
      DB_IDLE = 3'b001,
      DB_WAIT = 3'b010,
      DB_FIRE = 3'b100
   } db_state_t;
endpackage : hub_cfg_pkg

// *** hw/hub_cfg_regs.sv ***
`timescale 1ns/1ps
`include "hub_cfg_consts.svh"
module hub_cfg_regs
   import hub_cfg_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic cfg_wr_in,
   input wire logic [7:0] cfg_addr_in,
   input wire logic [7:0] cfg_wdata_in,
   output logic [7:0] cfg_rdata_out,
   input wire logic [3:0] port_owner_select_pins_in,
   output logic [4:0] manufacturer_text_length_out,
   output logic [4:0] product_text_length_out,
   output logic [4:0] serial_text_length_out,
   output logic [3:0] switch_ports_out,
   output logic switch_start_out
);
   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic rst_s1_q, rst_s2_q;
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   wire rst_n = rst_s2_q;

   function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   function automatic logic [7:0] clamp_len(input logic [7:0] v);
      clamp_len = (v > `TEXT_MAX_CHARS) ? `TEXT_MAX_CHARS : v;
   endfunction : clamp_len

   // ----------------------------------------
   // string storage
   // ----------------------------------------
   // one flat array; byte n of a region sits at region base + n, low byte of each character first
   localparam int unsigned STORE_BYTES = 3 * `TEXT_BYTES;
   logic [7:0] text_q [STORE_BYTES];
   logic [7:0] mfr_len_q, prd_len_q, ser_len_q, delay_q;
   wire text_hit = in_range(cfg_addr_in, `ADDR_MFR_FIRST, `ADDR_SER_LAST);
   wire [7:0] text_idx = cfg_addr_in - `ADDR_MFR_FIRST;

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < STORE_BYTES; i++) begin
            text_q[i] <= `RESET_BYTE;
         end
      end else if (cfg_wr_in && text_hit) begin
         text_q[text_idx] <= cfg_wdata_in;
      end
   end

   // over-long lengths are clipped so a descriptor never runs past its region
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         mfr_len_q <= `RESET_BYTE;
         prd_len_q <= `RESET_BYTE;
         ser_len_q <= `RESET_BYTE;
         delay_q <= `RESET_BYTE;
      end else if (cfg_wr_in) begin
         if (cfg_addr_in == `ADDR_MFR_LEN) begin
            mfr_len_q <= clamp_len(cfg_wdata_in);
         end
         if (cfg_addr_in == `ADDR_PRD_LEN) begin
            prd_len_q <= clamp_len(cfg_wdata_in);
         end
         if (cfg_addr_in == `ADDR_SER_LEN) begin
            ser_len_q <= clamp_len(cfg_wdata_in);
         end
         if (cfg_addr_in == `ADDR_DELAY) begin
            delay_q <= cfg_wdata_in;
         end
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         cfg_rdata_out <= `RESET_BYTE;
      end else if (text_hit) begin
         cfg_rdata_out <= text_q[text_idx];
      end else begin
         unique case (cfg_addr_in)
            `ADDR_MFR_LEN: cfg_rdata_out <= mfr_len_q;
            `ADDR_PRD_LEN: cfg_rdata_out <= prd_len_q;
            `ADDR_SER_LEN: cfg_rdata_out <= ser_len_q;
            `ADDR_DELAY: cfg_rdata_out <= delay_q;
            default: cfg_rdata_out <= `RESET_BYTE;
         endcase
      end
   end
   assign manufacturer_text_length_out = mfr_len_q[4:0];
   assign product_text_length_out = prd_len_q[4:0];
   assign serial_text_length_out = ser_len_q[4:0];

   // ----------------------------------------
   // select pin debounce
   // ----------------------------------------
   logic [3:0] sel_s1_q, sel_s2_q, sel_last_q, stable_q, ports_q;
   logic [7:0] ms_left_q;
   logic tick, fire_q;
   db_state_t state_q;
   wire changed = (sel_s2_q != sel_last_q);

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         sel_s1_q <= 4'h0;
         sel_s2_q <= 4'h0;
      end else begin
         sel_s1_q <= port_owner_select_pins_in;
         sel_s2_q <= sel_s1_q;
      end
   end

   // arming waits until sync chain and sel_last_q hold real pin levels,
   // so the level at release is the baseline and not a change
   logic [1:0] arm_q;
   logic armed_q;
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         arm_q <= 2'h0;
         armed_q <= 1'b0;
         sel_last_q <= 4'h0;
      end else begin
         arm_q <= {arm_q[0], 1'b1};
         armed_q <= arm_q[1];
         sel_last_q <= sel_s2_q;
      end
   end

   ms_tick_gen u_tick (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n),
      .restart_in(changed),
      .tick_out(tick)
   );

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= DB_IDLE;
         ms_left_q <= `RESET_BYTE;
         stable_q <= 4'h0;
         ports_q <= 4'h0;
         fire_q <= 1'b0;
      end else begin
         fire_q <= 1'b0;
         if (!armed_q) begin
            stable_q <= sel_s2_q;
         end else if (changed) begin
            state_q <= DB_WAIT;
            ms_left_q <= delay_q;
         end else begin
            unique case (state_q)
               DB_IDLE: ;
               DB_WAIT: begin
                  if (ms_left_q == `RESET_BYTE) begin
                     state_q <= DB_FIRE;
                  end else if (tick) begin
                     ms_left_q <= ms_left_q - 8'h01;
                  end
               end
               DB_FIRE: begin
                  // a bounce that returned to the old level moves nothing
                  ports_q <= sel_s2_q ^ stable_q;
                  fire_q <= (sel_s2_q != stable_q);
                  stable_q <= sel_s2_q;
                  state_q <= DB_IDLE;
               end
            endcase
         end
      end
   end
   assign switch_ports_out = ports_q;
   assign switch_start_out = fire_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_len_bound: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      mfr_len_q <= `TEXT_MAX_CHARS && prd_len_q <= `TEXT_MAX_CHARS && ser_len_q <= `TEXT_MAX_CHARS)
      else $error("string length above limit");
   a_len_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      cfg_wr_in && cfg_addr_in == `ADDR_MFR_LEN |=> mfr_len_q == clamp_len($past(cfg_wdata_in)))
      else $error("length write not stored");
   a_text_readback: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      cfg_wr_in && text_hit ##1 !cfg_wr_in && cfg_addr_in == $past(cfg_addr_in)
      |=> cfg_rdata_out == $past(cfg_wdata_in, 2))
      else $error("string byte readback wrong");
   a_outside_text: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      cfg_addr_in > `ADDR_SER_LAST && cfg_addr_in != `ADDR_DELAY |=> cfg_rdata_out == `RESET_BYTE)
      else $error("unmapped address read nonzero");
   a_mfr_region: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      cfg_addr_in == `ADDR_MFR_FIRST |-> text_hit && text_idx == 8'h00)
      else $error("manufacturer base misplaced");
   a_prd_region: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      cfg_addr_in == `ADDR_PRD_FIRST |-> text_idx == 8'(`TEXT_BYTES))
      else $error("product base misplaced");
   a_fire_ports: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      switch_start_out |-> switch_ports_out != 4'h0)
      else $error("switch started with no port");
   a_zero_delay: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      changed && delay_q == `RESET_BYTE ##1 !changed [*2] |=> state_q == DB_IDLE)
      else $error("zero delay did not finish");
   a_restart_wait: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      changed && armed_q |=> state_q == DB_WAIT && ms_left_q == $past(delay_q))
      else $error("change did not restart delay");
   a_no_early: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      state_q == DB_WAIT && ms_left_q != `RESET_BYTE |=> !switch_start_out)
      else $error("switch before delay expired");

   c_text_write: cover property (@(posedge clk_sys_in) disable iff (!rst_n) cfg_wr_in && text_hit);
   c_switch: cover property (@(posedge clk_sys_in) disable iff (!rst_n) switch_start_out);
   c_bounce: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
      state_q == DB_FIRE && sel_s2_q == stable_q);
endmodule : hub_cfg_regs

// *** hw/ms_tick_gen.sv ***
`timescale 1ns/1ps
`include "hub_cfg_consts.svh"
module ms_tick_gen (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic restart_in,
   output logic tick_out
);
   localparam int unsigned TICK_N = `TICK_CYCLES;
   logic [15:0] count_q;
   // restart aligns the first tick a full ms after a pin change
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_q <= 16'h0000;
      end else if (restart_in || count_q == 16'(TICK_N - 1)) begin
         count_q <= 16'h0000;
      end else begin
         count_q <= count_q + 16'h0001;
      end
   end
   assign tick_out = (count_q == 16'(TICK_N - 1)) && !restart_in;

   a_tick_period: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      tick_out |=> !tick_out)
      else $error("tick lasted more than one cycle");
endmodule : ms_tick_gen

// *** test/cfg_source_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// configuration source and select switches
// ----------------------------------------
module cfg_source_model (
   input wire logic clk_sys_in,
   input wire logic [7:0] cfg_rdata_in,
   output logic cfg_wr_out,
   output logic [7:0] cfg_addr_out,
   output logic [7:0] cfg_wdata_out,
   output logic [3:0] pins_out
);
   initial begin
      cfg_wr_out = 1'b0;
      cfg_addr_out = 8'h00;
      cfg_wdata_out = 8'h00;
      pins_out = 4'h0;
   end
   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      cfg_wr_out <= 1'b1;
      cfg_addr_out <= a;
      cfg_wdata_out <= d;
      @(posedge clk_sys_in);
      cfg_wr_out <= 1'b0;
      // released data must not keep the old value
      cfg_wdata_out <= ~d;
   endtask : wr_byte
   task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      cfg_addr_out <= a;
      // address held two edges, so either read alignment is safe
      @(posedge clk_sys_in);
      @(posedge clk_sys_in);
      #1 d = cfg_rdata_in;
   endtask : rd_byte
   task automatic put_char(input logic [7:0] base, input int k, input logic [15:0] c);
      wr_byte(base + 8'(2 * k), c[7:0]);
      wr_byte(base + 8'(2 * k + 1), c[15:8]);
   endtask : put_char
   task automatic set_pins(input logic [3:0] v);
      @(posedge clk_sys_in);
      pins_out <= v;
   endtask : set_pins
endmodule : cfg_source_model

// *** test/hub_cfg_regs_bench.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); err_total++; end end
module hub_cfg_regs_bench;
   logic clk_sys_in, rst_n_in, cfg_wr, switch_start_out;
   logic [7:0] cfg_addr, cfg_wdata, cfg_rdata_out, rd;
   logic [3:0] pins, switch_ports_out, cur, nxt;
   logic [4:0] len_m, len_p, len_s;
   logic [15:0] ch [3][31];
   logic [7:0] lens [4] = '{8'h1f, 8'h20, 8'hff, 8'h05};
   int checks = 0, err_total = 0, starts_seen = 0, n, cnt0;
   hub_cfg_regs i_hub_cfg_regs (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cfg_wr_in(cfg_wr),
      .cfg_addr_in(cfg_addr), .cfg_wdata_in(cfg_wdata), .cfg_rdata_out(cfg_rdata_out),
      .port_owner_select_pins_in(pins), .manufacturer_text_length_out(len_m),
      .product_text_length_out(len_p), .serial_text_length_out(len_s),
      .switch_ports_out(switch_ports_out), .switch_start_out(switch_start_out));
   cfg_source_model i_cfg_source_model (.clk_sys_in(clk_sys_in), .cfg_rdata_in(cfg_rdata_out),
      .cfg_wr_out(cfg_wr), .cfg_addr_out(cfg_addr), .cfg_wdata_out(cfg_wdata), .pins_out(pins));
   initial begin
      clk_sys_in = 1'b0;
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) if (switch_start_out === 1'b1) starts_seen <= starts_seen + 1;
   function automatic logic [3:0] exp_mask(input logic [3:0] o, input logic [3:0] v);
      return o ^ v;
   endfunction : exp_mask
   function automatic logic [7:0] exp_len(input logic [7:0] v);
      return (v > 8'h1f) ? 8'h1f : v;
   endfunction : exp_len
   function automatic logic [7:0] region_base(input int r);
      return (r == 0) ? 8'h16 : (r == 1) ? 8'h54 : 8'h92;
   endfunction : region_base
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   // bounded wait; a hang counts as a mismatch
   task automatic wait_start(input int bound, output int cnt);
      cnt = 0;
      while (switch_start_out !== 1'b1 && cnt < bound) begin
         @(posedge clk_sys_in);
         #1 cnt++;
      end
      if (cnt >= bound) begin
         err_total++;
         wrap_up();
      end
   endtask : wait_start
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst_n_in = 1'b0;
      void'($urandom(85346));
      repeat (3) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      for (int a = 0; a < 256; a++) begin
         i_cfg_source_model.rd_byte(8'(a), rd);
         `CHK("reset byte", 8'h00, rd)
      end
      // delay still at reset value zero, so switching is near immediate
      cur = 4'h0;
      for (int i = 0; i < 6; i++) begin
         nxt = (i == 0) ? 4'h1 : 4'($urandom);
         if (nxt == cur) nxt = ~cur;
         i_cfg_source_model.set_pins(nxt);
         wait_start(20, n);
         `CHK("switch ports", exp_mask(cur, nxt), switch_ports_out)
         cur = nxt;
         repeat (4) @(posedge clk_sys_in);
      end
      for (int r = 0; r < 3; r++) for (int k = 0; k < 31; k++) begin
         ch[r][k] = 16'($urandom);
         i_cfg_source_model.put_char(region_base(r), k, ch[r][k]);
      end
      // all regions written first so any aliasing shows on readback
      for (int r = 0; r < 3; r++) for (int k = 0; k < 31; k++) begin
         i_cfg_source_model.rd_byte(region_base(r) + 8'(2 * k), rd);
         `CHK("text low", ch[r][k][7:0], rd)
         i_cfg_source_model.rd_byte(region_base(r) + 8'(2 * k + 1), rd);
         `CHK("text high", ch[r][k][15:8], rd)
      end
      for (int v = 0; v < 4; v++) begin
         for (int r = 0; r < 3; r++) i_cfg_source_model.wr_byte(8'h13 + 8'(r), lens[v]);
         i_cfg_source_model.rd_byte(8'h14, rd);
         `CHK("length byte", exp_len(lens[v]), rd)
         `CHK("length mfr", exp_len(lens[v]), {3'h0, len_m})
         `CHK("length prd", exp_len(lens[v]), {3'h0, len_p})
         `CHK("length ser", exp_len(lens[v]), {3'h0, len_s})
      end
      i_cfg_source_model.wr_byte(8'hd1, 8'h5a);
      i_cfg_source_model.rd_byte(8'hd1, rd);
      `CHK("unmapped byte", 8'h00, rd)
      i_cfg_source_model.wr_byte(8'h12, 8'ha5);
      i_cfg_source_model.rd_byte(8'h12, rd);
      `CHK("below map", 8'h00, rd)
      i_cfg_source_model.wr_byte(8'hd0, 8'h01);
      i_cfg_source_model.rd_byte(8'hd0, rd);
      `CHK("delay byte", 8'h01, rd)
      // bounce on one pin, then a real change on another
      cnt0 = starts_seen;
      i_cfg_source_model.set_pins(cur ^ 4'h1);
      repeat (100) @(posedge clk_sys_in);
      i_cfg_source_model.set_pins(cur);
      // let the bounced delay run out: a return to the old level starts nothing
      repeat (40100) @(posedge clk_sys_in);
      `CHK("bounce start", 0, starts_seen - cnt0)
      i_cfg_source_model.set_pins(cur ^ 4'h4);
      repeat (100) @(posedge clk_sys_in);
      i_cfg_source_model.set_pins(cur ^ 4'h2);
      wait_start(40100, n);
      `CHK("delay cycles", 1'b1, (n >= 40000 && n <= 40020))
      `CHK("bounced ports", exp_mask(cur, cur ^ 4'h2), switch_ports_out)
      repeat (3) @(posedge clk_sys_in);
      `CHK("start count", 1, starts_seen - cnt0)
      wrap_up();
   end
endmodule : hub_cfg_regs_bench
